// ---- core/fmsr_defs.svh ----
`ifndef FMSR_DEFS_SVH
`define FMSR_DEFS_SVH

// Register byte offsets, low address byte only
`define FMSR_OFF_IRQ_STATUS 8'h00
`define FMSR_OFF_IRQ_MASK   8'h04
`define FMSR_OFF_CTRL       8'h08
`define FMSR_OFF_LAST_READ  8'h0c

// Event bit positions in status and mask
`define FMSR_EV_SINGLE  0
`define FMSR_EV_DOUBLE  1
`define FMSR_EV_REFUSED 2
`define FMSR_EV_W       3

// Control register
`define FMSR_CTRL_EN    0
`define FMSR_CTRL_RST   32'h0000_0001

// Read status codes
`define FMSR_ST_OK      2'h0
`define FMSR_ST_SINGLE  2'h1
`define FMSR_ST_DOUBLE  2'h2

// Page information word layout
`define FMSR_PS_CNT_HI  31
`define FMSR_PS_CNT_LO  8
`define FMSR_PS_RSV_HI  7
`define FMSR_PS_RSV_LO  4
`define FMSR_PS_OVT     3
`define FMSR_PS_RP      2
`define FMSR_PS_WP      1
`define FMSR_PS_LOCK    0
`define FMSR_CNT_W      24
`define FMSR_CNT_MAX    24'hff_ffff

// Last-read register layout
`define FMSR_LR_PAGE_LO 8

`endif

// ---- core/fmsr_mem_if.sv ----
`timescale 1ns/100ps
`default_nettype none

// Port of the page information memory
interface fmsr_mem_if #(parameter int AW = 6);
   logic          re;
   logic [AW-1:0] raddr;
   logic [31:0]   rdata;
   logic          we;
   logic [AW-1:0] waddr;
   logic [31:0]   wdata;

   modport ctrl (output re, output raddr, output we, output waddr, output wdata, input rdata);
   modport mem  (input re, input raddr, input we, input waddr, input wdata, output rdata);
endinterface

`default_nettype wire

// ---- core/fmsr_page_mem.sv ----
`timescale 1ns/100ps
`default_nettype none

module fmsr_page_mem #(
   parameter int PAGES = 64,
   parameter int AW    = 6
) (
   input  wire logic hclk,    // Clock
   input  wire logic hresetn, // Async reset, active low
   input  wire logic clk_en,  // Freezes state while low
   fmsr_mem_if.mem   port     // Read and write port
);

   logic [31:0] store [PAGES];

   // Array has no reset; the top sweeps it clean after reset
   always_ff @(posedge hclk) begin
      if (clk_en && port.we) begin
         store[port.waddr] <= port.wdata;
      end
   end

   // Registered read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port.rdata <= 32'h0000_0000;
      end else if (clk_en && port.re) begin
         port.rdata <= store[port.raddr];
      end
   end

endmodule

`default_nettype wire

// ---- core/fmsr_pkg.sv ----
package fmsr_pkg;

   // Page maintenance operations
   typedef enum logic [1:0] {
      FMSR_OP_PROGRAM,
      FMSR_OP_ERASE,
      FMSR_OP_UNPROTECT,
      FMSR_OP_TAP_PROTECT
   } fmsr_op_t;

   // Maintenance sequencer states
   typedef enum logic [1:0] {
      FMSR_CLEAR,
      FMSR_IDLE,
      FMSR_UPDATE
   } fmsr_state_t;

endpackage

// ---- core/fmsr_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fmsr_defs.svh"

module fmsr_top import fmsr_pkg::*; #(
   parameter int PAGES = 64,
   parameter int AW    = 6
) (
   input  wire logic          hclk,                   // Clock, 100 MHz
   input  wire logic          hresetn,                // Async reset, active low
   input  wire logic          clk_en,                 // Freezes all state while low
   input  wire logic          hsel,                   // AHB slave select
   input  wire logic [31:0]   haddr,                  // AHB address
   input  wire logic [1:0]    htrans,                 // AHB transfer type
   input  wire logic          hwrite,                 // AHB write
   input  wire logic [2:0]    hsize,                  // AHB size, word only
   input  wire logic [31:0]   hwdata,                 // AHB write data
   input  wire logic          hready,                 // AHB bus ready
   output logic               hreadyout,              // AHB slave ready
   output logic [31:0]        hrdata,                 // AHB read data
   output logic               hresp,                  // AHB response, OKAY
   input  wire logic          rd_strobe,              // User read request
   input  wire logic          page_info_select,       // Read page info, not data
   input  wire logic [AW-1:0] rd_page,                // Addressed page
   input  wire logic [31:0]   arr_rdata,              // Raw array data
   input  wire logic [31:0]   arr_err_mask,           // Flipped bit from checker
   input  wire logic          arr_err_double,         // Uncorrectable error seen
   output logic               rd_valid,               // Read result pulse
   output logic [31:0]        rd_data,                // Read result
   output logic [1:0]         rd_status,              // Read status code
   input  wire logic          op_strobe,              // Page maintenance request
   input  wire fmsr_op_t      op_code,                // Maintenance operation
   input  wire logic [AW-1:0] op_page,                // Maintenance page
   input  wire logic          overwrite_lock_request, // Lock page on program
   input  wire logic          over_threshold,         // Program over threshold
   input  wire logic          tap_rp,                 // Test-port read protect
   input  wire logic          tap_wp,                 // Test-port write protect
   output logic               busy,                   // Sequencer not idle
   output logic               op_done,                // Operation applied pulse
   output logic               op_refused,             // Operation refused pulse
   output logic               irq                     // Level interrupt
);

   ////////////////////////////////////////////////////////////////////////////
   // Memory and shared signals
   fmsr_mem_if #(.AW(AW)) mem_port ();
   fmsr_page_mem #(.PAGES(PAGES), .AW(AW)) u_mem (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clk_en  (clk_en),
      .port    (mem_port.mem)
   );

   logic [31:0]   ctrl;
   logic [31:0]   irq_mask;
   logic [`FMSR_EV_W-1:0] irq_status;
   logic [1:0]    last_code;
   logic [AW-1:0] last_page;
   logic          rd_take;
   // Status code from error indications
   function automatic logic [1:0] fmsr_code(input logic [31:0] mask, input logic dbl);
      if (dbl) begin
         return `FMSR_ST_DOUBLE;
      end else if (mask != 32'h0000_0000) begin
         return `FMSR_ST_SINGLE;
      end
      return `FMSR_ST_OK;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Maintenance sequencer
   fmsr_state_t   state, next_state;
   logic [AW-1:0] clr_page, next_clr_page;
   fmsr_op_t      op_q, next_op_q;
   logic [AW-1:0] op_page_q, next_op_page_q;
   logic [3:0]    op_flags, next_op_flags;
   logic          next_busy, next_op_done, next_op_refused;
   logic [31:0]   upd_word;
   logic [`FMSR_CNT_W-1:0] cnt;

   // Reads only while idle and enabled; reads win the memory port
   assign rd_take = rd_strobe && (state == FMSR_IDLE) && ctrl[`FMSR_CTRL_EN];
   always_comb begin
      next_state      = state;
      next_clr_page   = clr_page;
      next_op_q       = op_q;
      next_op_page_q  = op_page_q;
      next_op_flags   = op_flags;
      next_op_done    = 1'b0;
      next_op_refused = 1'b0;
      mem_port.re     = rd_take;
      mem_port.raddr  = rd_page;
      mem_port.we     = 1'b0;
      mem_port.waddr  = clr_page;
      mem_port.wdata  = 32'h0000_0000;
      upd_word        = mem_port.rdata;
      cnt             = mem_port.rdata[`FMSR_PS_CNT_HI:`FMSR_PS_CNT_LO];
      unique case (state)
         FMSR_CLEAR: begin
            // Counts and flags start at zero after reset
            mem_port.we   = 1'b1;
            next_clr_page = AW'(clr_page + 1'b1);
            if (clr_page == AW'(PAGES - 1)) begin
               next_state = FMSR_IDLE;
            end
         end
         FMSR_IDLE: begin
            if (op_strobe && !rd_take) begin
               mem_port.re    = 1'b1;
               mem_port.raddr = op_page;
               next_op_q      = op_code;
               next_op_page_q = op_page;
               next_op_flags  = {over_threshold, tap_rp, tap_wp, overwrite_lock_request};
               next_state     = FMSR_UPDATE;
            end
         end
         FMSR_UPDATE: begin
            mem_port.waddr = op_page_q;
            next_state     = FMSR_IDLE;
            if (cnt != `FMSR_CNT_MAX) begin
               cnt = cnt + 24'h00_0001;      // Saturates rather than wraps
            end
            unique case (op_q)
               FMSR_OP_PROGRAM, FMSR_OP_ERASE: begin
                  if (mem_port.rdata[`FMSR_PS_LOCK]) begin
                     next_op_refused = 1'b1;
                  end else begin
                     upd_word[`FMSR_PS_CNT_HI:`FMSR_PS_CNT_LO] = cnt;
                     if (op_q == FMSR_OP_PROGRAM) begin
                        upd_word[`FMSR_PS_OVT]  = op_flags[3];
                        upd_word[`FMSR_PS_LOCK] = op_flags[0];
                     end
                  end
               end
               FMSR_OP_UNPROTECT: begin
                  upd_word[`FMSR_PS_LOCK] = 1'b0;
               end
               FMSR_OP_TAP_PROTECT: begin
                  upd_word[`FMSR_PS_RP] = op_flags[2];
                  upd_word[`FMSR_PS_WP] = op_flags[1];
               end
            endcase
            upd_word[`FMSR_PS_RSV_HI:`FMSR_PS_RSV_LO] = 4'h0;
            mem_port.we    = !next_op_refused;
            mem_port.wdata = upd_word;
            next_op_done   = !next_op_refused;
         end
      endcase
      next_busy = (next_state != FMSR_IDLE);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state      <= FMSR_CLEAR;
         clr_page   <= '0;
         op_q       <= FMSR_OP_PROGRAM;
         op_page_q  <= '0;
         op_flags   <= 4'h0;
         busy       <= 1'b1;
         op_done    <= 1'b0;
         op_refused <= 1'b0;
      end else if (clk_en) begin
         state      <= next_state;
         clr_page   <= next_clr_page;
         op_q       <= next_op_q;
         op_page_q  <= next_op_page_q;
         op_flags   <= next_op_flags;
         busy       <= next_busy;
         op_done    <= next_op_done;
         op_refused <= next_op_refused;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read pipeline: capture, then result from memory or array
   logic        s1_valid, next_s1_valid;
   logic        s1_info, next_s1_info;
   logic [31:0] s1_data, next_s1_data;
   logic [1:0]  s1_code, next_s1_code;
   logic [31:0] next_rd_data;
   logic [1:0]  next_rd_status;

   always_comb begin
      next_s1_valid  = rd_take;
      next_s1_info   = page_info_select;
      next_s1_code   = fmsr_code(arr_err_mask, arr_err_double);
      // Correction only when the single flip is trustworthy
      next_s1_data   = arr_err_double ? arr_rdata : (arr_rdata ^ arr_err_mask);
      next_rd_data   = s1_info ? mem_port.rdata : s1_data;
      next_rd_status = s1_info ? `FMSR_ST_OK : s1_code;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_valid  <= 1'b0;
         s1_info   <= 1'b0;
         s1_data   <= 32'h0000_0000;
         s1_code   <= `FMSR_ST_OK;
         rd_valid  <= 1'b0;
         rd_data   <= 32'h0000_0000;
         rd_status <= `FMSR_ST_OK;
      end else if (clk_en) begin
         s1_valid <= next_s1_valid;
         s1_info  <= next_s1_info;
         s1_data  <= next_s1_data;
         s1_code  <= next_s1_code;
         rd_valid <= s1_valid;
         if (s1_valid) begin
            rd_data   <= next_rd_data;
            rd_status <= next_rd_status;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   logic        addr_ok, next_wr_pend, wr_pend;
   logic [7:0]  wr_addr, next_wr_addr;
   logic [31:0] next_hrdata, next_ctrl, next_irq_mask;
   logic [`FMSR_EV_W-1:0] events, w1c, next_irq_status;
   logic [1:0]  next_last_code;
   logic [AW-1:0] next_last_page;

   assign addr_ok = hsel && htrans[1] && hready;
   always_comb begin
      next_wr_pend = addr_ok && hwrite;
      next_wr_addr = haddr[7:0];
      next_hrdata  = 32'h0000_0000;      // Unmapped reads give zero
      if (addr_ok && !hwrite) begin
         unique case (haddr[7:0])
            `FMSR_OFF_IRQ_STATUS: next_hrdata = 32'(irq_status);
            `FMSR_OFF_IRQ_MASK:   next_hrdata = irq_mask;
            `FMSR_OFF_CTRL:       next_hrdata = ctrl;
            `FMSR_OFF_LAST_READ:  next_hrdata = (32'(last_page) << `FMSR_LR_PAGE_LO)
                                                | 32'(last_code);
            default:              next_hrdata = 32'h0000_0000;
         endcase
      end
      next_ctrl     = ctrl;
      next_irq_mask = irq_mask;
      w1c           = '0;
      if (wr_pend) begin
         unique case (wr_addr)
            `FMSR_OFF_IRQ_STATUS: w1c = hwdata[`FMSR_EV_W-1:0];
            `FMSR_OFF_IRQ_MASK:   next_irq_mask = hwdata & 32'(3'h7);
            `FMSR_OFF_CTRL:       next_ctrl = hwdata & `FMSR_CTRL_RST;
            default:              next_ctrl = ctrl;
         endcase
      end
      // A new event in the clearing cycle survives the clear
      events[`FMSR_EV_SINGLE]  = s1_valid && !s1_info && (s1_code == `FMSR_ST_SINGLE);
      events[`FMSR_EV_DOUBLE]  = s1_valid && !s1_info && (s1_code == `FMSR_ST_DOUBLE);
      events[`FMSR_EV_REFUSED] = next_op_refused;
      next_irq_status = (irq_status & ~w1c) | events;
      next_last_code  = s1_valid ? next_rd_status : last_code;
      next_last_page  = rd_take ? rd_page : last_page;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         hrdata     <= 32'h0000_0000;
         wr_pend    <= 1'b0;
         wr_addr    <= 8'h00;
         ctrl       <= `FMSR_CTRL_RST;
         irq_mask   <= 32'h0000_0000;
         irq_status <= '0;
         irq        <= 1'b0;
         last_code  <= `FMSR_ST_OK;
         last_page  <= '0;
      end else if (clk_en) begin
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         hrdata     <= next_hrdata;
         wr_pend    <= next_wr_pend;
         wr_addr    <= next_wr_addr;
         ctrl       <= next_ctrl;
         irq_mask   <= next_irq_mask;
         irq_status <= next_irq_status;
         irq        <= |(next_irq_status & next_irq_mask[`FMSR_EV_W-1:0]);
         last_code  <= next_last_code;
         last_page  <= next_last_page;
      end
   end

endmodule

`default_nettype wire

// ---- verification/fmsr_top_sva.sv ----
`timescale 1ns/100ps
`default_nettype none

module fmsr_top_sva import fmsr_pkg::*; (
   input wire logic        hclk,             // Clock
   input wire logic        hresetn,          // Reset, active low
   input wire logic        busy,             // Sequencer busy
   input wire logic        rd_strobe,        // Read request
   input wire logic        page_info_select, // Info select
   input wire logic [31:0] arr_rdata,        // Raw data
   input wire logic [31:0] arr_err_mask,     // Flip mask
   input wire logic        arr_err_double,   // Double error
   input wire logic        rd_valid,         // Result pulse
   input wire logic [31:0] rd_data,          // Result
   input wire logic [1:0]  rd_status,        // Status code
   input wire logic        op_strobe,        // Op request
   input wire fmsr_op_t    op_code,          // Op code
   input wire logic        op_done,          // Op applied
   input wire logic        op_refused        // Op refused
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////
   // Read results, latency two from the taking edge
   a_valid_cause: assert property (
      rd_valid |-> $past(rd_strobe, 2) && !$past(busy, 2)) else $error("result without request");
   a_single_fix: assert property (
      rd_strobe && !busy && !page_info_select && !arr_err_double && arr_err_mask != 32'h0
      ##2 rd_valid |-> rd_status == 2'h1 && (rd_data ^ $past(arr_err_mask, 2)) == $past(arr_rdata, 2))
      else $error("single error not corrected");
   a_double_raw: assert property (
      rd_strobe && !busy && !page_info_select && arr_err_double ##2 rd_valid
      |-> rd_status == 2'h2 && rd_data == $past(arr_rdata, 2)) else $error("double error wrong");
   a_clean_ok: assert property (
      rd_strobe && !busy && !page_info_select && !arr_err_double && arr_err_mask == 32'h0
      ##2 rd_valid |-> rd_status == 2'h0 && rd_data == $past(arr_rdata, 2)) else $error("clean read wrong");
   // Info reads ignore whatever the array checker claims
   a_info_code: assert property (
      rd_strobe && !busy && page_info_select ##2 rd_valid |-> rd_status == 2'h0)
      else $error("info read status not zero");
   a_info_rsvd: assert property (
      rd_strobe && !busy && page_info_select ##2 rd_valid |-> rd_data[7:4] == 4'h0)
      else $error("info reserved field not zero");

   ////////////////////////////////////////////////////////////////////////
   // Maintenance sequencing and refusal
   a_op_answer: assert property (
      op_strobe && !busy && !rd_strobe |=> busy ##1 (!busy && (op_done || op_refused)))
      else $error("operation not answered");
   a_refuse_kind: assert property (
      op_refused |-> $past(op_code, 2) == FMSR_OP_PROGRAM || $past(op_code, 2) == FMSR_OP_ERASE)
      else $error("refusal of wrong operation");
endmodule

bind fmsr_top fmsr_top_sva chk_u (.*);

`default_nettype wire

// ---- verification/fmsr_user_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module fmsr_user_model import fmsr_pkg::*; #(parameter int AW = 6) (
   input  wire logic          hclk,                   // Clock
   output logic               rd_strobe,              // Read request
   output logic               page_info_select,       // Info select
   output logic [AW-1:0]      rd_page,                // Read page
   output logic [31:0]        arr_rdata,              // Raw data
   output logic [31:0]        arr_err_mask,           // Flip mask
   output logic               arr_err_double,         // Double error
   input  wire logic          rd_valid,               // Result pulse
   input  wire logic [31:0]   rd_data,                // Result
   input  wire logic [1:0]    rd_status,              // Status code
   output logic               op_strobe,              // Op request
   output fmsr_op_t           op_code,                // Op code
   output logic [AW-1:0]      op_page,                // Op page
   output logic               overwrite_lock_request, // Lock on program
   output logic               over_threshold,         // Threshold flag
   output logic               tap_rp,                 // Read protect
   output logic               tap_wp,                 // Write protect
   input  wire logic          op_done,                // Op applied
   input  wire logic          op_refused              // Op refused
);
   // Quiet outputs from time zero
   initial begin
      {rd_strobe, page_info_select, rd_page, arr_rdata, arr_err_mask, arr_err_double} = '0;
      {op_strobe, op_page, overwrite_lock_request, over_threshold, tap_rp, tap_wp} = '0;
      op_code = FMSR_OP_PROGRAM;
   end

   // One read; raw data and flip mask turn to junk once the strobe drops
   task automatic rd(input logic i, input logic [AW-1:0] p, input logic [31:0] raw, m,
                     input logic dbl, output logic [31:0] d, output logic [1:0] s);
      @(posedge hclk);
      rd_strobe <= 1'b1;
      page_info_select <= i;
      rd_page <= p;
      arr_rdata <= raw;
      arr_err_mask <= m;
      arr_err_double <= dbl;
      @(posedge hclk);
      rd_strobe <= 1'b0;
      arr_rdata <= ~raw;
      arr_err_mask <= ~m;
      d = 'x;
      s = 'x;
      repeat (4) begin
         @(posedge hclk);
         #1;
         if (rd_valid === 1'b1) begin
            d = rd_data;
            s = rd_status;
            break;
         end
      end
   endtask

   // One maintenance operation; r tells whether it was refused
   task automatic op(input fmsr_op_t c, input logic [AW-1:0] p, input logic lk, ot, rp, wp,
                     output logic r);
      @(posedge hclk);
      op_strobe <= 1'b1;
      op_code <= c;
      op_page <= p;
      overwrite_lock_request <= lk;
      over_threshold <= ot;
      tap_rp <= rp;
      tap_wp <= wp;
      @(posedge hclk);
      op_strobe <= 1'b0;
      r = 'x;
      repeat (4) begin
         @(posedge hclk);
         #1;
         if (op_done === 1'b1 || op_refused === 1'b1) begin
            r = op_refused;
            break;
         end
      end
   endtask
endmodule

`default_nettype wire

// ---- verification/test_flash_read_status_reporting.sv ----
`timescale 1ns/100ps
`default_nettype none

`define FMSR_CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s expected %h seen %h", n, e, g); end end

module test_flash_read_status_reporting;
   import fmsr_pkg::*;
   logic hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp, irq, busy;
   logic rd_strobe, page_info_select, arr_err_double, rd_valid, op_strobe, op_done;
   logic overwrite_lock_request, over_threshold, tap_rp, tap_wp, op_refused;
   logic [31:0] haddr, hwdata, hrdata, arr_rdata, arr_err_mask, rd_data;
   logic [1:0]  htrans, rd_status;
   logic [2:0]  hsize, rd_page, op_page;
   fmsr_op_t    op_code;
   int          fail_count = 0;
   int          num_checks = 0;

   assign hready = hreadyout;
   fmsr_top #(.PAGES(8), .AW(3)) dut_u (.*);
   fmsr_user_model #(.AW(3)) user_u (.*);

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Single word bus transfer, no assumed wait count
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      `FMSR_CHK("hresp", 1'b0, hresp)
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Data reads: clean, corrected, uncorrectable
   task automatic t_reads;
      logic [31:0] d;
      logic [1:0]  s;
      user_u.rd(1'b0, 3'h1, 32'h1234_5678, 32'h0, 1'b0, d, s);
      `FMSR_CHK("clean", {32'h1234_5678, 2'h0}, {d, s})
      user_u.rd(1'b0, 3'h1, 32'h1234_5678, 32'h0000_0100, 1'b0, d, s);
      `FMSR_CHK("single", {32'h1234_5778, 2'h1}, {d, s})
      user_u.rd(1'b0, 3'h4, 32'ha5a5_0f0f, 32'h0000_0003, 1'b1, d, s);
      `FMSR_CHK("double", {32'ha5a5_0f0f, 2'h2}, {d, s})
      $display("t_reads done");
   endtask

   // Page info through program, protect, locked erase, unprotect, erase
   task automatic t_info;
      logic [31:0] d;
      logic [1:0]  s;
      logic        f;
      user_u.rd(1'b1, 3'h2, 32'hffff_ffff, 32'h0, 1'b1, d, s);
      `FMSR_CHK("info blank", {32'h0, 2'h0}, {d, s})
      user_u.op(FMSR_OP_PROGRAM, 3'h2, 1'b1, 1'b1, 1'b0, 1'b0, f);
      `FMSR_CHK("program", 1'b0, f)
      user_u.op(FMSR_OP_TAP_PROTECT, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1, f);
      `FMSR_CHK("protect", 1'b0, f)
      user_u.rd(1'b1, 3'h2, 32'h0, 32'h0, 1'b0, d, s);
      `FMSR_CHK("info locked", 32'h0000_010f, d)
      user_u.op(FMSR_OP_ERASE, 3'h2, 1'b0, 1'b0, 1'b0, 1'b0, f);
      `FMSR_CHK("erase locked", 1'b1, f)
      user_u.op(FMSR_OP_UNPROTECT, 3'h2, 1'b0, 1'b0, 1'b0, 1'b0, f);
      `FMSR_CHK("unprotect", 1'b0, f)
      user_u.op(FMSR_OP_ERASE, 3'h2, 1'b0, 1'b0, 1'b0, 1'b0, f);
      `FMSR_CHK("erase open", 1'b0, f)
      user_u.rd(1'b1, 3'h2, 32'h0, 32'h0, 1'b0, d, s);
      `FMSR_CHK("info erased", 32'h0000_020e, d)
      $display("t_info done");
   endtask

   // Sticky events, mask, clear, read gating, last read, unmapped place
   task automatic t_irq;
      logic [31:0] r;
      logic [31:0] d;
      logic [1:0]  s;
      ahb(1'b0, 8'h04, 32'h0, r);
      `FMSR_CHK("mask reset", 32'h0, r)
      ahb(1'b0, 8'h00, 32'h0, r);
      `FMSR_CHK("events", 32'h7, r)
      `FMSR_CHK("irq masked", 1'b0, irq)
      ahb(1'b1, 8'h04, 32'h7, r);
      repeat (2) @(posedge hclk);
      #1;
      `FMSR_CHK("irq on", 1'b1, irq)
      ahb(1'b1, 8'h00, 32'h7, r);
      repeat (2) @(posedge hclk);
      #1;
      `FMSR_CHK("irq off", 1'b0, irq)
      ahb(1'b0, 8'h0c, 32'h0, r);
      `FMSR_CHK("last read", 32'h0000_0200, r)
      // Reads off: an uncorrectable read must leave no trace
      ahb(1'b1, 8'h08, 32'h0, r);
      user_u.rd(1'b0, 3'h5, 32'h0, 32'h1, 1'b1, d, s);
      ahb(1'b0, 8'h00, 32'h0, r);
      `FMSR_CHK("gated events", 32'h0, r)
      ahb(1'b0, 8'h0c, 32'h0, r);
      `FMSR_CHK("gated last", 32'h0000_0200, r)
      ahb(1'b1, 8'h08, 32'h1, r);
      ahb(1'b0, 8'h08, 32'h0, r);
      `FMSR_CHK("ctrl", 32'h1, r)
      ahb(1'b0, 8'h10, 32'h0, r);
      `FMSR_CHK("unmapped", 32'h0, r)
      $display("t_irq done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog far beyond the hundred or so cycles the tests need
   initial begin
      repeat (5000) @(posedge hclk);
      fail_count++;
      print_verdict;
   end

   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
      clk_en = 1'b1;
      hsize = 3'h2;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (40) begin
         @(posedge hclk);
         #1;
         if (busy === 1'b0)
            break;
      end
      `FMSR_CHK("sweep done", 1'b0, busy)
      t_reads;
      t_info;
      t_irq;
      print_verdict;
   end
endmodule

`default_nettype wire
